// >>> core/tpd_io.sv
// Time-proportioned digital I/O point: output switching and input sensing.
// Operation
// - Digital off or zero percent demand keeps the output continuously off.
// - Digital on or full percent demand keeps the output continuously on.
// - Intermediate demand switches output so average on-time equals the percentage.
// - Fixed time base gives one on then one off interval per period.
// - Variable time base counts line cycles, switching at most every three.
// - Fixed period setting spans 0.1 to 60.0 seconds, used only in fixed mode.
// - Zero percent demand maps to zero, full to full, linear from low to high scale between.
// - The point is driven only when direction selects output.
// - Output direction accepts either on/off or percentage demand on one input.
// - Dry contact reports on for closure, off for open contact.
// - Voltage input reports off below 2 V and on above 3 V.
// - High scale setting, 0.0 to 100.0 percent, is the top of the scaled range; full demand gives 100.0 percent.
`timescale 1ns/1ps
module tpd_io #(
    parameter int TICK_CYCLES = tpd_pkg::TICK_CYCLES
) (
    input  wire logic                     clock,
    input  wire logic                     rst,
    input  wire tpd_pkg::tpd_dir_t        direction,
    input  wire tpd_pkg::tpd_tb_t         time_base,
    input  wire logic [tpd_pkg::PCT_W-1:0] fixed_period,
    input  wire logic [tpd_pkg::PCT_W-1:0] demand_pct,
    input  wire logic                     demand_digital,
    input  wire logic                     demand_on,
    input  wire logic [tpd_pkg::PCT_W-1:0] low_scale,
    input  wire logic [tpd_pkg::PCT_W-1:0] high_scale,
    input  wire logic                     line_cycle,
    input  wire logic                     contact_closed,
    input  wire logic                     contact_open,
    input  wire logic                     volt_high,
    input  wire logic                     volt_low,
    input  wire logic                     point_in,
    output logic                          point_out,
    output logic                          point_oe,
    output logic                          input_state,
    output logic      [tpd_pkg::PCT_W-1:0] active_pct
);
    import tpd_pkg::*;

    // Everything the point remembers apart from the scaled duty held in tpd_scale, registered as one word.
    typedef struct packed {
        logic [22:0]        tick_cnt;
        logic [PTICK_W-1:0] per_cnt;
        logic [PTICK_W-1:0] per_ticks;
        logic [PTICK_W-1:0] on_ticks;
        logic [PCT_W-1:0]   pct;
        logic [1:0]         vcyc;
        logic [ACC_W-1:0]   acc;
        logic               blk_on;
        logic               line_prev;
        logic               drive;
        logic               in_state;
    } tpd_io_state_t;

    tpd_io_state_t state_q;
    tpd_io_state_t state_d;

    logic [PCT_W-1:0] duty_pct;

    tpd_scale u_scale (
        .clock          (clock),
        .rst            (rst),
        .demand_pct     (demand_pct),
        .demand_digital (demand_digital),
        .demand_on      (demand_on),
        .low_scale      (low_scale),
        .high_scale     (high_scale),
        .duty_pct       (duty_pct)
    );

    function automatic logic [PCT_W-1:0] tpd_clamp_period(input logic [PCT_W-1:0] p);
        if (p < PERIOD_MIN) begin
            tpd_clamp_period = PERIOD_MIN;
        end else if (p > PERIOD_MAX) begin
            tpd_clamp_period = PERIOD_MAX;
        end else begin
            tpd_clamp_period = p;
        end
    endfunction : tpd_clamp_period

    function automatic logic tpd_is_output(input tpd_dir_t d);
        tpd_is_output = (d == DIR_OUTPUT);
    endfunction : tpd_is_output

    function automatic logic tpd_is_fixed(input tpd_tb_t t);
        tpd_is_fixed = (t == TB_FIXED);
    endfunction : tpd_is_fixed

    function automatic logic tpd_is_variable(input tpd_tb_t t);
        tpd_is_variable = (t == TB_VARIABLE);
    endfunction : tpd_is_variable

    function automatic logic tpd_fixed_level(input logic [PCT_W-1:0]   pct,
                                             input logic [PTICK_W-1:0] cnt,
                                             input logic [PTICK_W-1:0] on_len);
        if (pct == PCT_ZERO) begin
            tpd_fixed_level = 1'b0;
        end else if (pct == PCT_FULL) begin
            tpd_fixed_level = 1'b1;
        end else begin
            tpd_fixed_level = (cnt < on_len);
        end
    endfunction : tpd_fixed_level

    logic               tick;
    logic               line_edge;
    logic               period_end;
    logic               block_start;
    logic               block_full;
    logic [PCT_W-1:0]   per_tenths;
    logic [PTICK_W-1:0] new_per;
    logic [PTICK_W-1:0] new_on;
    logic [23:0]        on_prod;
    logic [ACC_W-1:0]   acc_sum;

    always_comb begin
        state_d     = state_q;
        // The tick is a one-cycle enable every TICK_CYCLES clocks; fixed-mode timing counts ticks.
        tick        = (state_q.tick_cnt == 23'(TICK_CYCLES - 1));
        line_edge   = line_cycle && !state_q.line_prev;
        // A zero period length exists only after reset, so the first period starts at the first tick.
        period_end  = (state_q.per_ticks == PTICK_W'(0)) || (state_q.per_cnt >= state_q.per_ticks - PTICK_W'(1));
        block_start = tpd_is_variable(time_base) && line_edge && (state_q.vcyc == 2'h0);
        per_tenths  = tpd_clamp_period(fixed_period);
        new_per     = PTICK_W'(per_tenths * TICKS_PER_TENTH);
        on_prod     = {14'h0000, per_tenths} * {14'h0000, duty_pct};
        new_on      = PTICK_W'(on_prod / 24'h000064);
        acc_sum     = {1'b0, state_q.acc[PCT_W-1:0]} + {1'b0, duty_pct};
        block_full  = (acc_sum >= {1'b0, PCT_FULL});

        state_d.line_prev = line_cycle;
        state_d.tick_cnt  = tick ? 23'h000000 : state_q.tick_cnt + 23'h000001;

        // Settings, and in fixed mode the duty, are latched only when a period ends, so a change never cuts an interval short.
        if (tick) begin
            if (period_end) begin
                state_d.per_cnt   = PTICK_W'(0);
                state_d.per_ticks = new_per;
                state_d.on_ticks  = new_on;
                if (tpd_is_fixed(time_base)) begin
                    state_d.pct = duty_pct;
                end
            end else begin
                state_d.per_cnt = state_q.per_cnt + PTICK_W'(1);
            end
        end

        // The accumulator carries what a block leaves over, so the average on-time matches the duty.
        if (block_start) begin
            state_d.pct = duty_pct;
            if (block_full) begin
                state_d.blk_on = 1'b1;
                state_d.acc    = acc_sum - {1'b0, PCT_FULL};
            end else begin
                state_d.blk_on = 1'b0;
                state_d.acc    = acc_sum;
            end
        end
        if (tpd_is_variable(time_base) && line_edge) begin
            state_d.vcyc = (state_q.vcyc == VAR_BLOCK_LAST) ? 2'h0 : state_q.vcyc + 2'h1;
        end

        // An unknown time base code keeps the output off rather than guessing a method.
        case (time_base)
            TB_FIXED: begin
                state_d.drive = tpd_fixed_level(state_d.pct, state_d.per_cnt, state_d.on_ticks);
            end
            TB_VARIABLE: begin
                state_d.drive = state_d.blk_on;
            end
            default: begin
                state_d.drive = 1'b0;
            end
        endcase

        // Between the two thresholds the sensed state holds, which gives the input its hysteresis.
        case (direction)
            DIR_DRY_CONTACT: begin
                if (contact_closed) begin
                    state_d.in_state = 1'b1;
                end else if (contact_open) begin
                    state_d.in_state = 1'b0;
                end else begin
                    state_d.in_state = state_q.in_state;
                end
            end
            DIR_VOLTAGE: begin
                if (volt_high) begin
                    state_d.in_state = 1'b1;
                end else if (volt_low) begin
                    state_d.in_state = 1'b0;
                end else begin
                    state_d.in_state = state_q.in_state;
                end
            end
            DIR_OUTPUT: begin
                state_d.in_state = point_in;
            end
            default: begin
                state_d.in_state = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    // The enable follows direction at once, so the pin is released in the cycle the point becomes an input.
    assign point_oe    = tpd_is_output(direction);
    assign point_out   = point_oe && state_q.drive;
    assign input_state = state_q.in_state;
    assign active_pct  = state_q.pct;
endmodule : tpd_io

// >>> core/tpd_scale.sv
// Demand selection and low/high power scaling.
`timescale 1ns/1ps
module tpd_scale (
    input  wire logic                     clock,
    input  wire logic                     rst,
    input  wire logic [tpd_pkg::PCT_W-1:0] demand_pct,
    input  wire logic                     demand_digital,
    input  wire logic                     demand_on,
    input  wire logic [tpd_pkg::PCT_W-1:0] low_scale,
    input  wire logic [tpd_pkg::PCT_W-1:0] high_scale,
    output logic      [tpd_pkg::PCT_W-1:0] duty_pct
);
    import tpd_pkg::*;

    typedef struct packed {
        logic [PCT_W-1:0] pct;
    } tpd_scale_state_t;

    tpd_scale_state_t state_q;
    tpd_scale_state_t state_d;

    function automatic logic [PCT_W-1:0] tpd_clamp_pct(input logic [PCT_W-1:0] v);
        tpd_clamp_pct = (v > PCT_FULL) ? PCT_FULL : v;
    endfunction : tpd_clamp_pct

    logic        [PCT_W-1:0] eff;
    logic        [PCT_W-1:0] lo;
    logic        [PCT_W-1:0] hi;
    logic signed [11:0]      span;
    logic signed [23:0]      prod;
    logic signed [23:0]      scaled;

    always_comb begin
        state_d = state_q;
        lo      = tpd_clamp_pct(low_scale);
        hi      = tpd_clamp_pct(high_scale);
        eff     = demand_digital ? (demand_on ? PCT_FULL : PCT_ZERO) : tpd_clamp_pct(demand_pct);
        span    = $signed({2'b00, hi}) - $signed({2'b00, lo});
        prod    = span * $signed({14'h0000, eff});
        scaled  = $signed({14'h0000, lo}) + prod / $signed(24'h0003e8);
        if (eff == PCT_ZERO) begin
            state_d.pct = PCT_ZERO;
        end else if (eff == PCT_FULL) begin
            state_d.pct = PCT_FULL;
        end else begin
            state_d.pct = scaled[PCT_W-1:0];
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    assign duty_pct = state_q.pct;
endmodule : tpd_scale

// >>> shared/tpd_pkg.sv
// Constants and types shared by the time-proportioned digital I/O point.
package tpd_pkg;
    localparam int          CLK_HZ          = 25_000_000;
    localparam int          TICK_MS         = 10;
    localparam int          TICK_CYCLES     = CLK_HZ / 1000 * TICK_MS;
    localparam int          TICKS_PER_TENTH = 100 / TICK_MS;
    localparam int          PCT_W           = 10;
    localparam logic [9:0]  PCT_FULL        = 10'h3e8;
    localparam logic [9:0]  PCT_ZERO        = 10'h000;
    localparam logic [9:0]  PERIOD_MIN      = 10'h001;
    localparam logic [9:0]  PERIOD_MAX      = 10'h258;
    localparam logic [9:0]  PERIOD_RESET    = 10'h064;
    localparam int          PTICK_W         = 13;
    localparam logic [1:0]  VAR_BLOCK_LAST  = 2'h2;
    localparam int          ACC_W           = 11;

    typedef enum logic [2:0] {
        DIR_DRY_CONTACT = 3'b001,
        DIR_OUTPUT      = 3'b010,
        DIR_VOLTAGE     = 3'b100
    } tpd_dir_t;

    typedef enum logic [1:0] {
        TB_FIXED    = 2'b01,
        TB_VARIABLE = 2'b10
    } tpd_tb_t;
endpackage : tpd_pkg

// >>> testbench/tpd_chk.sv
// Port assertions for the digital I/O point.
`timescale 1ns/1ps
module tpd_chk (
    input wire logic                          clock,
    input wire logic                          rst,
    input wire tpd_pkg::tpd_dir_t             direction,
    input wire tpd_pkg::tpd_tb_t              time_base,
    input wire logic                          line_cycle,
    input wire logic                          contact_closed,
    input wire logic                          contact_open,
    input wire logic                          volt_high,
    input wire logic                          volt_low,
    input wire logic                          point_out,
    input wire logic                          point_oe,
    input wire logic                          input_state,
    input wire logic [tpd_pkg::PCT_W-1:0]     active_pct
);
    import tpd_pkg::*;
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    logic       line_q;
    logic       out_q;
    logic [1:0] edges_q;
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            line_q  <= 1'b0;
            out_q   <= 1'b0;
            edges_q <= 2'h0;
        end else begin
            line_q <= line_cycle;
            out_q  <= point_out;
            if (point_out != out_q) begin
                edges_q <= 2'h0;
            end else if (line_cycle && !line_q && edges_q != 2'h3) begin
                edges_q <= edges_q + 2'h1;
            end
        end
    end
    a_oe_dir: assert property (point_oe == (direction == DIR_OUTPUT)) else $error("enable wrong");
    a_out_gated: assert property (!point_oe |-> !point_out) else $error("driven as input");
    a_dry_on: assert property (direction == DIR_DRY_CONTACT && contact_closed |=> input_state)
        else $error("closure missed");
    a_dry_off: assert property (direction == DIR_DRY_CONTACT && contact_open |=> !input_state)
        else $error("open missed");
    a_volt_on: assert property (direction == DIR_VOLTAGE && volt_high |=> input_state)
        else $error("high missed");
    a_volt_off: assert property (direction == DIR_VOLTAGE && volt_low |=> !input_state)
        else $error("low missed");
    a_full_on: assert property (time_base == TB_FIXED && point_oe && active_pct == PCT_FULL
        && $stable(active_pct) |-> point_out) else $error("full not on");
    a_zero_off: assert property (time_base == TB_FIXED && active_pct == PCT_ZERO
        && $stable(active_pct) |-> !point_out) else $error("zero not off");
    a_var_edge: assert property (time_base == TB_VARIABLE && $stable(direction) && $stable(time_base)
        && $changed(point_out) |-> $past(line_cycle) || $past(line_cycle, 2) || $past(line_cycle, 3))
        else $error("switch off line edge");
    a_var_three: assert property (time_base == TB_VARIABLE && $stable(time_base) && $stable(direction)
        && point_out != out_q |-> edges_q == 2'h3) else $error("switched within three line cycles");
endmodule : tpd_chk

bind tpd_io tpd_chk u_chk (.clock, .rst, .direction, .time_base, .line_cycle, .contact_closed, .contact_open,
    .volt_high, .volt_low, .point_out, .point_oe, .input_state, .active_pct);

// >>> testbench/tpd_field.sv
// Field side model: line reference, contact and voltage sensing, pin load.
`timescale 1ns/1ps
module tpd_field (
    input  wire logic       clock,
    input  wire logic [1:0] sense,
    input  wire logic       point_out,
    input  wire logic       point_oe,
    output logic            line_cycle,
    output logic            contact_closed,
    output logic            contact_open,
    output logic            volt_high,
    output logic            volt_low,
    output logic            point_in
);
    logic [4:0] ph_q = 5'h00;
    always_ff @(posedge clock) begin
        ph_q <= (ph_q == 5'h13) ? 5'h00 : ph_q + 5'h01;
    end
    assign line_cycle = ph_q < 5'h0a;
    // Sense code 2 is a closure or a high level, 0 open or low, 1 lies between the thresholds.
    assign contact_closed = sense == 2'h2;
    assign contact_open   = sense == 2'h0;
    assign volt_high      = sense == 2'h2;
    assign volt_low       = sense == 2'h0;
    // The load pulls the pin low when nothing drives it.
    assign point_in = point_oe ? point_out : 1'b0;
endmodule : tpd_field

// >>> testbench/tpd_io_tb_top.sv
// Self-checking bench for the digital I/O point.
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin num_errors++; \
    $display("ERROR t=%0t got %h exp %h", $time, (a), (b)); end end
module tpd_io_tb_top;
    import tpd_pkg::*;
    typedef struct { logic [9:0] pct; logic dig, on; logic [9:0] lo, hi, exp; int hi_clk; } tpd_row_t;
    tpd_row_t   rows [7] = '{'{10'h000, 1'b0, 1'b0, 10'h0c8, 10'h320, 10'h000, 0},
        '{10'h3e8, 1'b0, 1'b0, 10'h0c8, 10'h320, 10'h3e8, 40}, '{10'h1f4, 1'b0, 1'b0, 10'h000, 10'h3e8, 10'h1f4, 20},
        '{10'h0fa, 1'b0, 1'b0, 10'h0c8, 10'h320, 10'h15e, 12}, '{10'h000, 1'b1, 1'b1, 10'h000, 10'h3e8, 10'h3e8, 40},
        '{10'h1f4, 1'b1, 1'b0, 10'h000, 10'h3e8, 10'h000, 0}, '{10'h12c, 1'b0, 1'b0, 10'h064, 10'h064, 10'h064, 4}};
    logic       clock = 1'b0, rst = 1'b1, demand_digital = 1'b0, demand_on = 1'b0;
    tpd_dir_t   direction = DIR_OUTPUT;
    tpd_tb_t    time_base = TB_FIXED;
    logic [9:0] fixed_period = 10'h001, demand_pct = 10'h000, low_scale = 10'h000, high_scale = 10'h3e8;
    logic [1:0] sense = 2'h0;
    logic       line_cycle, contact_closed, contact_open, volt_high, volt_low, point_in;
    logic       point_out, point_oe, input_state;
    logic [9:0] active_pct;
    int         num_errors = 0, n_tests = 0, cyc = 0;
    integer     hi;
    always #20 clock = ~clock;
    tpd_io #(.TICK_CYCLES(4)) dut_u (.clock, .rst, .direction, .time_base, .fixed_period, .demand_pct,
        .demand_digital, .demand_on, .low_scale, .high_scale, .line_cycle, .contact_closed, .contact_open,
        .volt_high, .volt_low, .point_in, .point_out, .point_oe, .input_state, .active_pct);
    tpd_field field_u (.clock, .sense, .point_out, .point_oe, .line_cycle, .contact_closed, .contact_open,
        .volt_high, .volt_low, .point_in);
    task automatic print_verdict();
        $display("Checks %0d, errors %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : print_verdict
    task automatic measure(input int n);
        hi = 0;
        repeat (n) begin
            @(negedge clock);
            hi = hi + point_out;
        end
    endtask : measure
    task automatic sense_chk(input logic [1:0] s, input logic exp);
        sense = s;
        repeat (2) @(negedge clock);
        `CHK(input_state, exp)
    endtask : sense_chk
    always @(posedge clock) begin
        cyc++;
        if (cyc == 4000) begin
            num_errors++;
            print_verdict();
        end
    end
    initial begin
        repeat (8) @(negedge clock);
        rst = 1'b0;
        `CHK(active_pct, PCT_ZERO)
        foreach (rows[i]) begin
            {demand_pct, demand_digital, demand_on, low_scale, high_scale} =
                {rows[i].pct, rows[i].dig, rows[i].on, rows[i].lo, rows[i].hi};
            repeat (80) @(negedge clock);
            `CHK(active_pct, rows[i].exp)
            measure(40);
            `CHK(hi, rows[i].hi_clk)
            if (rows[i].hi_clk == 0 || rows[i].hi_clk == 40) `CHK(input_state, rows[i].hi_clk != 0)
        end
        // A zero period setting is clamped to the shortest period.
        {fixed_period, demand_pct, low_scale, high_scale} = {10'h000, 10'h1f4, 10'h000, 10'h3e8};
        repeat (80) @(negedge clock);
        for (int k = 0; k < 50 && point_out !== 1'b0; k++) @(negedge clock);
        for (int k = 0; k < 50 && point_out !== 1'b1; k++) @(negedge clock);
        demand_pct = 10'h000;
        repeat (10) @(negedge clock);
        `CHK(point_out, 1'b1)
        `CHK(active_pct, 10'h1f4)
        repeat (40) @(negedge clock);
        `CHK(active_pct, PCT_ZERO)
        demand_pct = 10'h1f4;
        time_base  = TB_VARIABLE;
        repeat (240) @(negedge clock);
        measure(240);
        `CHK(hi, 120)
        direction = DIR_DRY_CONTACT;
        sense_chk(2'h2, 1'b1);
        `CHK(point_oe, 1'b0)
        sense_chk(2'h1, 1'b1);
        sense_chk(2'h0, 1'b0);
        direction = DIR_VOLTAGE;
        sense_chk(2'h2, 1'b1);
        sense_chk(2'h1, 1'b1);
        sense_chk(2'h0, 1'b0);
        print_verdict();
    end
endmodule : tpd_io_tb_top
